// *** src/amr_dev.sv ***
`timescale 1ns/100ps
module amr_dev
  import amr_pkg::*;
(
  // Clock and reset
  input  wire logic                CLOCK,
  input  wire logic                SRST,
  // Link
  amr_if.dev                       LINK,
  // Analog sample stand-in and power-on strap
  input  wire logic [RES_BITS-1:0] SAMPLE_IN,
  input  wire logic                START_SHUT,
  // Status
  output logic                     SHUTDOWN,
  output logic                     TRACKING,
  output logic                     RESULT_VALID
);
  // Input synchronisers
  logic [1:0] sel_s, clk_s;
  logic       sel_d, clk_d;
  always_ff @(posedge CLOCK)
  begin
    sel_s <= {sel_s[0], LINK.sel_n};
    clk_s <= {clk_s[0], LINK.sclk};
    sel_d <= sel_s[1];
    clk_d <= clk_s[1];
  end
  wire sel_fall  = sel_d & ~sel_s[1];
  wire sel_rise  = ~sel_d & sel_s[1];
  wire clk_fall  = clk_d & ~clk_s[1];
  wire clk_rise  = ~clk_d & clk_s[1];
  wire in_frame  = ~sel_s[1];

  logic                 strap_done_r;
  logic [4:0]           fall_r, rise_r;
  logic                 shut_r, drive_r, wake_r, dummy_r, track_r, dout_r;
  logic [14:0]          shreg_r;

  wire [4:0] fall_nxt = (fall_r == FALLS_FULL) ? fall_r : fall_r + 5'h01;
  // Fall count as seen by a select rise, a coincident fall included
  wire [4:0] falls_seen = clk_fall ? fall_nxt : fall_r;

  // Frame control
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      fall_r <= 5'h00; rise_r <= 5'h00; shut_r <= 1'b0; drive_r <= 1'b0;
      wake_r <= 1'b0; dummy_r <= 1'b1; track_r <= 1'b1; dout_r <= 1'b0;
      shreg_r <= 15'h0000;
    end
    // power-on mode taken from the strap
    else if (!strap_done_r)
      shut_r <= START_SHUT;
    else if (sel_fall)
    begin
      fall_r  <= 5'h00;
      rise_r  <= 5'h00;
      drive_r <= 1'b1;
      track_r <= 1'b0;
      wake_r  <= shut_r;
      shut_r  <= 1'b0;
      // a wake frame makes the result unusable
      dummy_r <= dummy_r | shut_r;
      // First zero stands from the select fall, the rest follow on falls
      dout_r  <= 1'b0;
      shreg_r <= {{(LEAD_ZEROS-1){1'b0}}, SAMPLE_IN, 1'b0};
    end
    else if (sel_rise)
    begin
      drive_r <= 1'b0;
      track_r <= 1'b1;
      if (falls_seen < FALLS_NOISE)
        shut_r <= wake_r;
      else if (falls_seen <= FALLS_SHUT)
        shut_r <= 1'b1;
      if (falls_seen == FALLS_FULL)
        dummy_r <= wake_r;
      wake_r <= 1'b0;
    end
    else if (in_frame)
    begin
      if (clk_fall)
      begin
        fall_r  <= fall_nxt;
        dout_r  <= shreg_r[14];
        shreg_r <= {shreg_r[13:0], 1'b0};
        if (fall_nxt == FALLS_FULL)
        begin
          drive_r <= 1'b0;
          dummy_r <= wake_r;
          wake_r  <= 1'b0;
        end
      end
      if (clk_rise && rise_r != FALLS_FULL)
      begin
        rise_r <= rise_r + 5'h01;
        if (rise_r + 5'h01 == RISE_TRACK)
          track_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      strap_done_r <= 1'b0;
    else
      strap_done_r <= 1'b1;
  end
  // Outputs; dummy flag
  assign LINK.dout      = dout_r;
  assign LINK.dout_oe_n = ~drive_r;
  assign SHUTDOWN       = shut_r;
  assign TRACKING       = track_r;
  assign RESULT_VALID   = ~dummy_r & ~shut_r;
endmodule

// *** src/amr_host.sv ***
`timescale 1ns/100ps
module amr_host
  import amr_pkg::*;
(
  // Clock and reset
  input  wire logic                CLOCK,
  input  wire logic                SRST,
  // Link
  amr_if.host                      LINK,
  // Request: stop_at = falls before raising select, zero gives twenty
  input  wire logic                START,
  input  wire logic [4:0]          STOP_AT,
  output logic                     BUSY,
  // Answer
  output logic [RES_BITS-1:0]      RESULT,
  output logic                     DONE
);
  typedef enum logic [2:0] {H_IDLE = 3'b001, H_RUN = 3'b010, H_QUIET = 3'b100} amr_hst_e;
  amr_hst_e   st_r;
  logic [7:0] div_r, qt_r;
  logic [4:0] falls_r, stop_r;
  logic       sclk_r, sel_r, done_r;
  logic [15:0] cap_r;
  logic [1:0] din_s;
  always_ff @(posedge CLOCK) din_s <= {din_s[0], LINK.dout};

  wire tick = (div_r == SCLK_HALF_DIV - 8'h01);

  // Host sequencer; kept by caller timing
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      st_r <= H_IDLE; div_r <= 8'h00; qt_r <= 8'h00; falls_r <= 5'h00;
      stop_r <= 5'h00; sclk_r <= 1'b1; sel_r <= 1'b1; done_r <= 1'b0;
      cap_r <= 16'h0000;
    end
    else
    begin
      done_r <= 1'b0;
      case (st_r)
        H_IDLE:
          if (START)
          begin
            st_r <= H_RUN; sel_r <= 1'b0; falls_r <= 5'h00; div_r <= 8'h00;
            stop_r <= (STOP_AT == 5'h00) ? FRAME_CYCLES : STOP_AT;
          end
        H_RUN:
        begin
          div_r <= tick ? 8'h00 : div_r + 8'h01;
          if (tick)
          begin
            sclk_r <= ~sclk_r;
            if (sclk_r)
            begin
              falls_r <= falls_r + 5'h01;
              // Only the sixteen bits of the word are kept
              if (falls_r < FALLS_FULL)
                cap_r <= {cap_r[14:0], din_s[1]};
              if (falls_r + 5'h01 == stop_r)
              begin
                sel_r <= 1'b1; st_r <= H_QUIET; qt_r <= 8'h00;
                done_r <= 1'b1;
              end
            end
          end
        end
        H_QUIET:
        begin
          // Clock returns high a full half period after the last fall
          if (qt_r == SCLK_HALF_DIV - 8'h01)
            sclk_r <= 1'b1;
          qt_r <= qt_r + 8'h01;
          if (qt_r >= QUIET_CNT && sclk_r)
            st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign LINK.sel_n = sel_r;
  assign LINK.sclk  = sclk_r;
  assign BUSY       = (st_r != H_IDLE);
  // Bits four to fifteen of the word hold the result
  assign RESULT     = cap_r[RES_BITS:1];
  assign DONE       = done_r;
endmodule

// *** src/amr_if.sv ***
`timescale 1ns/100ps
interface amr_if;
  import amr_pkg::*;
  logic sel_n;
  logic sclk;
  logic dout;
  logic dout_oe_n;
  modport dev (input sel_n, input sclk, output dout, output dout_oe_n);
  modport host (output sel_n, output sclk, input dout, input dout_oe_n);
endinterface

// *** src/amr_pkg.sv ***
package amr_pkg;
  // -------------------------------------------------------------
  // Frame timing
  // -------------------------------------------------------------
  localparam int          RES_BITS       = 12;
  localparam int          LEAD_ZEROS     = 3;
  localparam logic [4:0]  FALLS_FULL     = 5'h10;
  localparam logic [4:0]  FALLS_NOISE    = 5'h02;
  localparam logic [4:0]  FALLS_SHUT     = 5'h0A;
  localparam logic [4:0]  RISE_TRACK     = 5'h0D;
  localparam logic [4:0]  FRAME_CYCLES   = 5'h14;
  localparam int          CLOCK_PERIOD_NS = 8;
  localparam int          QUIET_NS       = 50;
  localparam int          QUIET_CYC      = (QUIET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0]  SCLK_HALF_DIV  = 8'h0A;
  localparam logic [7:0]  QUIET_CNT      = 8'(QUIET_CYC);
endpackage

// *** tb/amr_properties.sv ***
`timescale 1ns/100ps
module amr_properties
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // Link
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe_n
);
  logic       sclk_r;
  logic [4:0] cnt_r;
  wire        fall = sclk_r & ~sclk;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Link clock falls in the frame, held at sixteen
  always_ff @(posedge CLOCK)
  begin
    sclk_r <= sclk;
    cnt_r  <= sel_n ? 5'h0 : cnt_r + {4'h0, fall && cnt_r != 5'h10};
  end
  // ---------------------------------
  // Wire checks
  // ---------------------------------
  sequence s_rel;
    ##[0:6] dout_oe_n;
  endsequence
  sequence s_drv;
    ##[1:6] !dout_oe_n;
  endsequence
  a_rel_on_rise: assert property ($rose(sel_n) |-> s_rel)
    else $error("output held after select rise");
  a_drive_on_fall: assert property ($fell(sel_n) |-> s_drv)
    else $error("output not driven after select fall");
  a_rel_after_full: assert property ($rose(cnt_r == 5'h10) |-> s_rel)
    else $error("output held after sixteen falls");
  a_drive_in_frame: assert property (!dout_oe_n |-> !sel_n || !$past(sel_n, 6))
    else $error("output driven outside frame");
  a_lead_zeros: assert property ($fell(sel_n) || fall && cnt_r < 5'h2 |-> ##6 (dout_oe_n || !dout))
    else $error("leading bit not zero");
  a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk)[*8])
    else $error("link clock half period too short");
  a_quiet_gap: assert property ($rose(sel_n) |=> sel_n[*6])
    else $error("select fell inside quiet interval");
  a_no_fall_idle: assert property (fall |-> !$past(sel_n))
    else $error("link clock fell outside frame");
endmodule

// *** tb/tb_adc_mode_and_readout_ctrl.sv ***
`timescale 1ns/100ps
module tb_adc_mode_and_readout_ctrl;
  import amr_pkg::*;
  logic        clock;
  logic        srst;
  logic        start;
  logic        start_shut;
  logic        shutdown;
  logic        tracking;
  logic        valid;
  logic        busy;
  logic        done;
  logic [4:0]  stop_at;
  logic [11:0] sample;
  logic [11:0] result;
  int          num_errors;
  int          comparisons;
  amr_if link();
  amr_dev i_amr_dev (.CLOCK(clock), .SRST(srst), .LINK(link), .SAMPLE_IN(sample),
    .START_SHUT(start_shut), .SHUTDOWN(shutdown), .TRACKING(tracking), .RESULT_VALID(valid));
  amr_host i_amr_host (.CLOCK(clock), .SRST(srst), .LINK(link), .START(start),
    .STOP_AT(stop_at), .BUSY(busy), .RESULT(result), .DONE(done));
  amr_properties i_props (.CLOCK(clock), .SRST(srst), .sel_n(link.sel_n),
    .sclk(link.sclk), .dout(link.dout), .dout_oe_n(link.dout_oe_n));
  // Clock generator
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ---------------------------------
  // Shared tasks
  // ---------------------------------
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One frame with n falls (twenty when n is zero), waits until the host is idle again
  task run(input logic [4:0] n);
    int k;
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    start   <= 1'b1;
    stop_at <= n;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    @(negedge clock);
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
    begin
      seen = seen | (done === 1'b1);
      @(negedge clock);
    end
    chk(12'(seen), 12'h1);
    if (k == 2000)
    begin
      num_errors++;
      print_verdict();
    end
  endtask
  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task t_wake;
    chk(12'(shutdown), 12'h1);
    sample <= 12'ha5c;
    run(5'h10);
    chk(12'({valid, shutdown}), 12'h0);
    run(5'h0);
    chk(result, 12'ha5c);
    chk(12'({valid, tracking}), 12'h3);
    $display("test wake done");
  endtask
  task t_modes;
    logic [4:0] stops [9];
    logic       expd [9];
    stops = '{5'h1, 5'hc, 5'hf, 5'ha, 5'h5, 5'hb, 5'h2, 5'h1, 5'h10};
    expd  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 9; i++)
    begin
      run(stops[i]);
      chk(12'(shutdown), 12'(expd[i]));
    end
    $display("test modes done");
  endtask
  task t_back;
    sample <= 12'h801;
    run(5'h0);
    chk(result, 12'h801);
    sample <= 12'h7fe;
    run(5'h10);
    chk(result, 12'h7fe);
    $display("test back done");
  endtask
  // Main sequence
  initial
  begin
    srst        = 1'b1;
    start       = 1'b0;
    start_shut  = 1'b1;
    stop_at     = 5'h0;
    sample      = 12'h0;
    num_errors  = 0;
    comparisons = 0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(negedge clock);
    t_wake();
    t_modes();
    t_back();
    print_verdict();
  end
endmodule
